//--- intc_pkg.sv
/*
 * constants, state type and register map of the vectored interrupt unit.
 * assumes one 100 MHz clock and a synchronous active-high reset.
 */
package intc_pkg;

    localparam int NUM_SRC = 6;
    localparam int PC_W    = 12;

    // register addresses
    localparam logic [7:0] ADDR_PRIORITY = 8'hF9;
    localparam logic [7:0] ADDR_REQUEST  = 8'hFA;
    localparam logic [7:0] ADDR_MASK     = 8'hFB;

    // values after reset
    localparam logic [7:0] RESET_PRIORITY = 8'h00;
    localparam logic [7:0] RESET_REQUEST  = 8'h00;
    localparam logic [7:0] RESET_MASK     = 8'h00;
    localparam logic [7:0] RESET_RDATA    = 8'h00;

    // field positions
    localparam int MASK_GLOBAL_BIT  = 7;
    localparam int MASK_PROTECT_BIT = 6;
    localparam int EDGE_BIT1_BIT    = 7;
    localparam int EDGE_BIT2_BIT    = 6;

    // source numbers
    localparam int SRC_ZERO    = 0;
    localparam int SRC_ONE     = 1;
    localparam int SRC_TWO     = 2;
    localparam int SRC_TIMER_A = 4;
    localparam int SRC_TIMER_B = 5;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } cycle_state_t;

endpackage

//--- vectored_interrupt_unit.sv
/*
 * vectored, prioritised interrupt unit with polled-mode request register.
 * assumes pins and comparators are asynchronous; timer pulses, register
 * port and core handshake are on ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module vectored_interrupt_unit
    import intc_pkg::*;
#(
    parameter bit PROTECT_OPTION = 1'b1
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              port3_bit1_input,
    input  wire logic              port3_bit2_input,
    input  wire logic              port3_bit3_input,
    input  wire logic              first_comparator_output,
    input  wire logic              second_comparator_output,
    input  wire logic              analog_mode,
    input  wire logic              timer_a_end_of_count,
    input  wire logic              timer_b_end_of_count,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic              core_cycle_done,
    output logic      [7:0]        reg_rdata,
    output logic                   int_grant,
    output logic                   int_active,
    output logic      [2:0]        int_source,
    output logic      [PC_W-1:0]   vector_address,
    output logic                   ram_protect
);

    // synchroniser and edge history, bit order p31 p32 p33 cmp1 cmp2
    logic [4:0]       sync1_reg;
    logic [4:0]       sync2_reg;
    logic [4:0]       prev_reg;
    logic [4:0]       pins;
    logic [4:0]       rise;
    logic [4:0]       fall;
    logic             b1_rise;
    logic             b1_fall;
    logic             b2_rise;
    logic             b2_fall;
    logic [5:0]       events;

    // register file and cycle state
    logic [7:0]       flags_reg;
    logic [7:0]       flags_next;
    logic [7:0]       mask_reg;
    logic [7:0]       mask_next;
    logic [7:0]       prio_reg;
    logic [7:0]       prio_next;
    logic [7:0]       rdata_reg;
    logic [7:0]       rdata_next;
    cycle_state_t     state_reg;
    cycle_state_t     state_next;
    logic             grant_reg;
    logic             grant_next;
    logic [2:0]       src_reg;
    logic [2:0]       src_next;
    logic [PC_W-1:0]  vec_reg;
    logic [PC_W-1:0]  vec_next;
    logic             prot_reg;
    logic             prot_next;
    logic [5:0]       pending;
    logic             found;
    logic [2:0]       win;
    logic             wr_req;
    logic             wr_mask;
    logic             wr_prio;

    // clock and reset shared by every check below
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    assign pins = {second_comparator_output, first_comparator_output,
                   port3_bit3_input, port3_bit2_input, port3_bit1_input};

    // two-stage synchroniser, then one history stage for edges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            prev_reg  <= 5'h00;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // edge detection and polarity selection per source
    always_comb begin
        rise    = sync2_reg & ~prev_reg;
        fall    = ~sync2_reg & prev_reg;
        b1_rise = analog_mode ? rise[3] : rise[0];
        b1_fall = analog_mode ? fall[3] : fall[0];
        b2_rise = analog_mode ? rise[4] : rise[1];
        b2_fall = analog_mode ? fall[4] : fall[1];
        events  = 6'h00;
        events[SRC_ZERO] = (b2_rise & flags_reg[EDGE_BIT2_BIT])
            | (b2_fall & (~flags_reg[EDGE_BIT2_BIT]
                          | flags_reg[EDGE_BIT1_BIT]));
        events[SRC_ONE] = fall[2];
        events[SRC_TWO] = (b1_rise & flags_reg[EDGE_BIT1_BIT])
            | (b1_fall & (~flags_reg[EDGE_BIT1_BIT]
                          | flags_reg[EDGE_BIT2_BIT]));
        events[SRC_TIMER_A] = timer_a_end_of_count;
        events[SRC_TIMER_B] = timer_b_end_of_count;
    end

    // rotating priority search from the programmed start source
    always_comb begin
        logic [3:0] idx;
        logic [3:0] start;
        idx     = 4'h0;
        start   = (prio_reg[2:0] > 3'h5) ? 4'h0 : {1'b0, prio_reg[2:0]};
        pending = flags_reg[5:0] & mask_reg[5:0]
                  & {6{mask_reg[MASK_GLOBAL_BIT]}};
        found   = 1'b0;
        win     = 3'h0;
        for (int k = 0; k < NUM_SRC; k++) begin
            idx = start + 4'(k);
            if (idx > 4'h5) begin
                idx = idx - 4'h6;
            end
            if (!found && pending[idx[2:0]]) begin
                found = 1'b1;
                win   = idx[2:0];
            end
        end
    end

    // register writes, grant sequencing and read data
    always_comb begin
        wr_req     = reg_wr && (reg_addr == ADDR_REQUEST);
        wr_mask    = reg_wr && (reg_addr == ADDR_MASK);
        wr_prio    = reg_wr && (reg_addr == ADDR_PRIORITY);
        flags_next = wr_req ? reg_wdata : flags_reg;
        mask_next  = wr_mask ? reg_wdata : mask_reg;
        prio_next  = wr_prio ? reg_wdata : prio_reg;
        state_next = state_reg;
        grant_next = 1'b0;
        src_next   = src_reg;
        vec_next   = vec_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (found) begin
                    state_next = ST_BUSY;
                    grant_next = 1'b1;
                    src_next   = win;
                    vec_next   = PC_W'({win, 1'b0});
                    flags_next[win] = 1'b0;
                    mask_next[MASK_GLOBAL_BIT] = 1'b0;
                end
            end
            ST_BUSY: begin
                if (core_cycle_done) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
        // hardware events win over any clear in the same cycle
        flags_next[5:0] = flags_next[5:0] | events;
        prot_next  = PROTECT_OPTION & mask_next[MASK_PROTECT_BIT];
        rdata_next = rdata_reg;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_REQUEST:  rdata_next = flags_reg;
                ADDR_MASK:     rdata_next = mask_reg;
                ADDR_PRIORITY: rdata_next = prio_reg;
                default:       rdata_next = 8'h00;
            endcase
        end
    end

    // state registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags_reg <= RESET_REQUEST;
            mask_reg  <= RESET_MASK;
            prio_reg  <= RESET_PRIORITY;
            rdata_reg <= RESET_RDATA;
            state_reg <= ST_IDLE;
            grant_reg <= 1'b0;
            src_reg   <= 3'h0;
            vec_reg   <= '0;
            prot_reg  <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            mask_reg  <= mask_next;
            prio_reg  <= prio_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
            grant_reg <= grant_next;
            src_reg   <= src_next;
            vec_reg   <= vec_next;
            prot_reg  <= prot_next;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata      = rdata_reg;
    assign int_grant      = grant_reg;
    assign int_active     = (state_reg == ST_BUSY);
    assign int_source     = src_reg;
    assign vector_address = vec_reg;
    assign ram_protect    = prot_reg;

    // checks on the unit's own behaviour
    property p_req_one_fall;
        fall[2] |=> flags_reg[SRC_ONE];
    endproperty
    a_req_one_fall: assert property (p_req_one_fall)
        else $error("falling edge on bit 3 did not set request one");

    property p_req_one_no_rise;
        (rise[2] && !flags_reg[SRC_ONE] && !wr_req)
            |=> !flags_reg[SRC_ONE];
    endproperty
    a_req_one_no_rise: assert property (p_req_one_no_rise)
        else $error("rising edge on bit 3 set request one");

    property p_req_two_rise;
        (b1_rise && flags_reg[EDGE_BIT1_BIT]) |=> flags_reg[SRC_TWO];
    endproperty
    a_req_two_rise: assert property (p_req_two_rise)
        else $error("selected rising edge missed on request two");

    property p_req_zero_sel;
        (b2_fall && !flags_reg[EDGE_BIT2_BIT] && !flags_reg[SRC_ZERO]
            && !wr_req && !b2_rise) |=> flags_reg[SRC_ZERO];
    endproperty
    a_req_zero_sel: assert property (p_req_zero_sel)
        else $error("falling edge missed on request zero");

    property p_timers;
        (timer_a_end_of_count |=> flags_reg[SRC_TIMER_A])
            and (timer_b_end_of_count |=> flags_reg[SRC_TIMER_B]);
    endproperty
    a_timers: assert property (p_timers)
        else $error("timer end of count not recorded");

    property p_global_gate;
        !mask_reg[MASK_GLOBAL_BIT] |=> !int_grant;
    endproperty
    a_global_gate: assert property (p_global_gate)
        else $error("grant while globally disabled");

    property p_grant_pending;
        int_grant
            |-> ($past(pending) & (6'h01 << int_source)) != 6'h00;
    endproperty
    a_grant_pending: assert property (p_grant_pending)
        else $error("granted source was not pending and enabled");

    property p_grant_disables;
        int_grant |-> !mask_reg[MASK_GLOBAL_BIT] && int_active
            ##1 !int_grant;
    endproperty
    a_grant_disables: assert property (p_grant_disables)
        else $error("grant left interrupts enabled or repeated");

    property p_busy_no_grant;
        int_active |=> !int_grant;
    endproperty
    a_busy_no_grant: assert property (p_busy_no_grant)
        else $error("second grant while a cycle was active");

    property p_vector;
        int_grant |-> vector_address == PC_W'({int_source, 1'b0});
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector address does not match source");

    property p_poll_read;
        (reg_rd && reg_addr == ADDR_REQUEST)
            |=> reg_rdata == $past(flags_reg);
    endproperty
    a_poll_read: assert property (p_poll_read)
        else $error("request register read wrong");

    property p_protect;
        ##1 ram_protect == (PROTECT_OPTION && mask_reg[MASK_PROTECT_BIT]);
    endproperty
    a_protect: assert property (p_protect)
        else $error("ram protect does not follow mask bit 6");

    property p_grant_clears;
        (int_grant && (($past(events) & (6'h01 << int_source)) == 6'h00))
            |-> !flags_reg[int_source];
    endproperty
    a_grant_clears: assert property (p_grant_clears)
        else $error("granted flag still pending");

    c_grant: cover property (int_grant ##[1:20] !int_active);
    c_poll: cover property (!mask_reg[MASK_GLOBAL_BIT] && timer_a_end_of_count
        ##1 reg_rd && reg_addr == ADDR_REQUEST);
    c_both_edges: cover property (flags_reg[7:6] == 2'b11 && b1_fall);
    c_analog: cover property (analog_mode && b2_rise);

endmodule
`default_nettype wire

//--- core_model.sv
/*
 * behavioural model of the core that services each interrupt cycle.
 * assumes int_active from the unit and the shared ref_clk and rst.
 */
`timescale 1ns/100ps
`default_nettype none
module core_model #(
    parameter int SERVICE_CYCLES = 4
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic int_active,
    output logic      core_cycle_done
);
    logic [7:0] cnt;

    // count the service time, then end the machine cycle with one pulse
    always_ff @(posedge ref_clk) begin
        if (rst || !int_active || core_cycle_done) begin
            cnt             <= 8'h00;
            core_cycle_done <= 1'b0;
        end else begin
            cnt             <= cnt + 8'h01;
            core_cycle_done <= (cnt == 8'(SERVICE_CYCLES));
        end
    end
endmodule
`default_nettype wire

//--- testbench.sv
/*
 * self-checking bench for the vectored interrupt unit.
 * assumes intc_pkg and core_model; one 100 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import intc_pkg::*;
    logic ref_clk = 0, rst = 1, p1 = 0, p2 = 0, p3 = 0, c1 = 0, c2 = 0;
    logic an = 0, ta = 0, tb = 0, wr = 0, rd = 0, done;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic grant, active, prot;
    logic [2:0] src;
    logic [PC_W-1:0] vec;
    int n_errors = 0, checks_done = 0;

    always #5 ref_clk = ~ref_clk;

    vectored_interrupt_unit u_vectored_interrupt_unit (
        .ref_clk(ref_clk), .rst(rst), .port3_bit1_input(p1),
        .port3_bit2_input(p2), .port3_bit3_input(p3),
        .first_comparator_output(c1), .second_comparator_output(c2),
        .analog_mode(an), .timer_a_end_of_count(ta),
        .timer_b_end_of_count(tb), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .core_cycle_done(done),
        .reg_rdata(rdata), .int_grant(grant), .int_active(active),
        .int_source(src), .vector_address(vec), .ram_protect(prot));

    core_model u_core_model (.ref_clk(ref_clk), .rst(rst),
        .int_active(active), .core_cycle_done(done));

    // compare one value
    task chk(input string nm, input logic [11:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wreg(input logic [7:0] a, d);
        @(posedge ref_clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task rreg(input logic [7:0] a, exp);
        @(posedge ref_clk);
        addr <= a; rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 chk("reg_rdata", {4'h0, rdata}, {4'h0, exp});
    endtask

    task waitc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // wait for a grant and check who won, then let the core finish
    task expect_grant(input logic [2:0] s);
        int i;
        for (i = 0; i < 20 && grant !== 1'b1; i++) @(posedge ref_clk) #1;
        chk("int_grant", {11'h0, grant}, 12'h001);
        chk("int_source", {9'h0, src}, {9'h0, s});
        chk("vector_address", vec, {8'h0, s, 1'b0});
        chk("int_active", {11'h0, active}, 12'h001);
        for (i = 0; i < 20 && active !== 1'b0; i++) @(posedge ref_clk) #1;
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        report_and_stop;
    end

    // main sequence
    initial begin
        waitc(3);
        rst <= 1'b0;
        rreg(ADDR_PRIORITY, RESET_PRIORITY);
        rreg(ADDR_REQUEST, RESET_REQUEST);
        rreg(ADDR_MASK, RESET_MASK);
        rreg(8'hF8, 8'h00);
        $display("test reset done");
        // timer a grant clears its flag and the global enable
        wreg(ADDR_MASK, 8'h90);
        @(posedge ref_clk) ta <= 1'b1;
        @(posedge ref_clk) ta <= 1'b0;
        expect_grant(3'h4);
        rreg(ADDR_REQUEST, 8'h00);
        rreg(ADDR_MASK, 8'h10);
        @(posedge ref_clk) tb <= 1'b1;
        @(posedge ref_clk) tb <= 1'b0;
        waitc(4);
        chk("int_active", {11'h0, active}, 12'h000);
        rreg(ADDR_REQUEST, 8'h20);
        $display("test timer done");
        // priority start at five, then wrap round to three
        wreg(ADDR_REQUEST, 8'h28);
        wreg(ADDR_PRIORITY, 8'h05);
        wreg(ADDR_MASK, 8'hA8);
        expect_grant(3'h5);
        wreg(ADDR_MASK, 8'hA8);
        expect_grant(3'h3);
        $display("test priority done");
        // polled mode: bit3 pin sets request one on falling edge only
        wreg(ADDR_MASK, 8'h02);
        wreg(ADDR_REQUEST, 8'h00);
        @(posedge ref_clk) p3 <= 1'b1;
        waitc(6);
        rreg(ADDR_REQUEST, 8'h00);
        @(posedge ref_clk) p3 <= 1'b0;
        waitc(6);
        rreg(ADDR_REQUEST, 8'h02);
        chk("int_active", {11'h0, active}, 12'h000);
        $display("test polling done");
        // edge select of request two over all four codes
        for (int m = 0; m < 4; m++) begin
            wreg(ADDR_REQUEST, 8'(m << 6));
            @(posedge ref_clk) p1 <= 1'b1;
            waitc(6);
            rreg(ADDR_REQUEST, 8'(m << 6) | (m[1] ? 8'h04 : 8'h00));
            wreg(ADDR_REQUEST, 8'(m << 6));
            @(posedge ref_clk) p1 <= 1'b0;
            waitc(6);
            rreg(ADDR_REQUEST, 8'(m << 6) | (m != 2 ? 8'h04 : 8'h00));
        end
        $display("test edges done");
        // comparators feed requests two and zero on rising edges, both edges selected
        @(posedge ref_clk) an <= 1'b1;
        waitc(6);
        wreg(ADDR_REQUEST, 8'hC0);
        @(posedge ref_clk) c1 <= 1'b1;
        c2 <= 1'b1;
        waitc(6);
        rreg(ADDR_REQUEST, 8'hC5);
        $display("test comparators done");
        // ram protect follows mask bit 6
        wreg(ADDR_MASK, 8'h40);
        #1 chk("ram_protect", {11'h0, prot}, 12'h001);
        wreg(ADDR_MASK, 8'h00);
        #1 chk("ram_protect", {11'h0, prot}, 12'h000);
        $display("test protect done");
        report_and_stop;
    end
endmodule
`default_nettype wire
